// ===== include/dpf_pkg.sv
// Purpose: shared constants and types for the detector data pipeline framer
// Assumes: one 25 MHz clock, ten readout paths feeding four serial links
// Notes: end-of-record codes and header layout live here so both files agree

package dpf_pkg;

	// ==========================================================================
	// structure
	localparam int NUM_PATHS = 10;
	localparam int NUM_LINKS = 4;
	localparam int PATHS_PER_LINK = 3;
	localparam int LANE_W = PATHS_PER_LINK * 8;
	localparam int PATH_W = 4;
	localparam int OUT_DEPTH = 4096;
	localparam int OUT_AW = 12;
	localparam int IN_DEPTH = 16;
	localparam int IN_AW = 4;
	localparam int PED_CHANS = 128;
	localparam int COUNT_W = 14;

	// ==========================================================================
	// framing
	localparam logic [1:0] HDR_LAST = 2'h3;
	localparam logic [1:0] EOR_STATUS_FRAMES = 2'h2;
	localparam logic [COUNT_W-1:0] EOR_MIN_FRAMES = 14'h0004;
	localparam logic [1:0] TOP_CHIP_ID = 2'b10;
	localparam logic [1:0] TOP_EOR = 2'b11;
	localparam logic [2:0] TOP_PHI_CHIP = 3'b101;
	localparam logic [2:0] TOP_Z_CHIP = 3'b100;
	localparam logic [7:0] RECORD_END_NORMAL = 8'hC1;
	localparam logic [7:0] RECORD_END_TRUNCATE = 8'hC2;
	localparam logic [7:0] RECORD_END_FILL = 8'hC4;
	localparam logic [7:0] RECORD_END_ABORT = 8'hC8;
	localparam logic [1:0] BE_QUIESCENT = 2'h0;
	localparam logic [1:0] BE_DIGITIZE = 2'h1;
	localparam logic [1:0] BE_READ = 2'h2;

	// ==========================================================================
	// timing
	localparam int CLK_FREQ_MHZ = 25;
	localparam int STROBE_SKEW_NS = 0;
	localparam int STROBE_SKEW_CYC = (STROBE_SKEW_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int STROBE_DELAY_CYCLES = (STROBE_SKEW_CYC < 1) ? 1 : STROBE_SKEW_CYC;

	typedef enum {FCU_IDLE, FCU_HEADER, FCU_READ, FCU_DRAIN, FCU_EOR} dpf_fcu_state_t;

	function automatic int link_of(input int p);
		return p / PATHS_PER_LINK;
	endfunction

	function automatic int lane_of(input int p);
		return p % PATHS_PER_LINK;
	endfunction

endpackage

// ===== verilog/dpf_path.sv
// Purpose: one readout path: link capture, input fifo, pedestal processor
// Assumes: link byte and toggle come from pins, everything else from clk logic
// Notes: injected header bytes carry a bypass tag and are never altered

`timescale 1ns/1ps
`default_nettype none

module dpf_path
	import dpf_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] link_byte,
	input wire logic link_valid_toggle,
	input wire logic link_wr_en,
	input wire logic inj_en,
	input wire logic inj_bypass,
	input wire logic [7:0] inj_data,
	input wire logic ped_wr_en,
	input wire logic [6:0] ped_wr_chan,
	input wire logic [7:0] ped_wr_value,
	output logic proc_valid,
	output logic [7:0] proc_data,
	output logic idle
);

	// ==========================================================================
	// link capture
	logic [7:0] byte_s1_q, byte_s2_q;
	logic tog_s1_q, tog_s2_q, tog_s3_q;
	logic [8:0] dly_q [STROBE_DELAY_CYCLES];

	// two flops on every pin before anything looks at it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			byte_s1_q <= 8'h00;
			byte_s2_q <= 8'h00;
			tog_s1_q <= 1'b0;
			tog_s2_q <= 1'b0;
			tog_s3_q <= 1'b0;
		end else begin
			byte_s1_q <= link_byte;
			byte_s2_q <= byte_s1_q;
			tog_s1_q <= link_valid_toggle;
			tog_s2_q <= tog_s1_q;
			tog_s3_q <= tog_s2_q;
		end
	end

	// both edges of the toggle mark a byte; data is aligned so a fixed delay suffices
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < STROBE_DELAY_CYCLES; i++) dly_q[i] <= 9'h000;
		end else begin
			dly_q[0] <= {tog_s2_q ^ tog_s3_q, byte_s2_q};
			for (int i = 1; i < STROBE_DELAY_CYCLES; i++) dly_q[i] <= dly_q[i-1];
		end
	end

	// ==========================================================================
	// input fifo, injection has priority over the link
	logic [8:0] in_mem [IN_DEPTH];
	logic [IN_AW:0] in_wr_q, in_rd_q;
	logic in_full, in_empty, push, pop;
	logic [8:0] push_word, head;

	assign in_full = (in_wr_q[IN_AW] != in_rd_q[IN_AW]) && (in_wr_q[IN_AW-1:0] == in_rd_q[IN_AW-1:0]);
	assign in_empty = (in_wr_q == in_rd_q);
	assign push_word = inj_en ? {inj_bypass, inj_data} : {1'b0, dly_q[STROBE_DELAY_CYCLES-1][7:0]};
	assign push = (inj_en | (link_wr_en & dly_q[STROBE_DELAY_CYCLES-1][8])) & ~in_full;
	assign pop = ~in_empty;
	assign head = in_mem[in_rd_q[IN_AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) in_mem[in_wr_q[IN_AW-1:0]] <= push_word;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			in_wr_q <= '0;
			in_rd_q <= '0;
		end else begin
			if (push) in_wr_q <= in_wr_q + 1'b1;
			if (pop) in_rd_q <= in_rd_q + 1'b1;
		end
	end

	// ==========================================================================
	// pedestal processor
	logic [7:0] ped_mem [PED_CHANS];
	logic [7:0] ped_q;
	logic expect_adc_q, expect_status_q;

	always_ff @(posedge clk) begin
		if (ped_wr_en) ped_mem[ped_wr_chan] <= ped_wr_value;
	end

	// channel byte fetches the pedestal, the next byte is the sample it applies to
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			proc_valid <= 1'b0;
			proc_data <= 8'h00;
			ped_q <= 8'h00;
			expect_adc_q <= 1'b0;
			expect_status_q <= 1'b0;
		end else begin
			proc_valid <= pop;
			if (pop) begin
				proc_data <= head[7:0];
				expect_adc_q <= 1'b0;
				expect_status_q <= 1'b0;
				if (head[8]) begin
					expect_adc_q <= 1'b0;
				end else if (expect_adc_q) begin
					proc_data <= (head[7:0] > ped_q) ? head[7:0] - ped_q : 8'h00;
				end else if (expect_status_q) begin
					proc_data <= head[7:0];
				end else if (head[7] == 1'b0) begin
					ped_q <= ped_mem[head[6:0]];
					expect_adc_q <= 1'b1;
				end else if (head[7:6] == TOP_CHIP_ID) begin
					expect_status_q <= 1'b1; // phi and z chip ids both pass whole
				end
			end
		end
	end

	assign idle = in_empty & ~proc_valid;

endmodule // dpf_path

`default_nettype wire

// ===== verilog/dpf_framer.sv
// Purpose: ten-path readout framer with header insertion, end-of-record framing
// Assumes: command and host strobes are one-cycle pulses on clk
// Notes: link bytes and toggles are pins and are synchronised inside each path

`timescale 1ns/1ps
`default_nettype none

module dpf_framer
	import dpf_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [NUM_PATHS-1:0][7:0] link_byte,
	input wire logic [NUM_PATHS-1:0] link_byte_valid,
	input wire logic digitize_cmd,
	input wire logic [7:0] cmd_bunch_crossing,
	input wire logic [1:0] cmd_backend_state,
	input wire logic readout_start,
	input wire logic readout_done,
	input wire logic readout_abort,
	input wire logic test_mode,
	input wire logic test_wr_en,
	input wire logic [7:0] test_byte,
	input wire logic id_wr_en,
	input wire logic [PATH_W-1:0] id_wr_path,
	input wire logic [7:0] id_cable_hi,
	input wire logic [3:0] id_board,
	input wire logic ped_wr_en,
	input wire logic [PATH_W-1:0] ped_wr_path,
	input wire logic [6:0] ped_wr_chan,
	input wire logic [7:0] ped_wr_value,
	input wire logic link_disable,
	input wire logic host_fifo_wr_en,
	input wire logic [PATH_W-1:0] host_fifo_wr_path,
	input wire logic [7:0] host_fifo_wr_data,
	input wire logic host_fifo_rd_en,
	input wire logic [PATH_W-1:0] host_fifo_rd_path,
	output logic fe_readout_clk_en,
	output logic [7:0] host_fifo_rd_data,
	output logic host_fifo_rd_valid,
	output logic [NUM_LINKS-1:0][LANE_W-1:0] link_word,
	output logic [NUM_LINKS-1:0] link_word_valid,
	output logic [NUM_PATHS-1:0] out_fifo_empty,
	output logic record_busy
);

	// ==========================================================================
	// shared signals
	dpf_fcu_state_t state_q;
	logic [1:0] hdr_idx_q;
	logic [7:0] bunch_q;
	logic [1:0] be_state_q;
	logic [7:0] cable_hi_q [NUM_PATHS];
	logic [3:0] board_q [NUM_PATHS];
	logic abort_q;
	logic inj_en, inj_bypass, link_wr_en, start_ok, end_req;
	logic [NUM_PATHS-1:0][7:0] inj_data;
	logic [NUM_PATHS-1:0] proc_valid, path_idle, eor_wr, path_done, pop, empty;
	logic [NUM_PATHS-1:0][7:0] proc_data, rd_word;
	logic [NUM_PATHS-1:0][COUNT_W-1:0] count_q;
	logic [NUM_LINKS-1:0][COUNT_W-1:0] link_target_q, target_d;
	logic [NUM_LINKS-1:0] grp_ready, drain;
	logic host_rd_ok;

	assign start_ok = (state_q == FCU_IDLE) & readout_start;
	assign end_req = readout_done | readout_abort;

	// ==========================================================================
	// command bus capture: bunch and state latched in the same cycle as a digitize
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bunch_q <= 8'h00;
			be_state_q <= BE_QUIESCENT;
		end else if (digitize_cmd) begin
			bunch_q <= cmd_bunch_crossing;
			be_state_q <= cmd_backend_state;
		end
	end

	// cable identification, loaded by the host during initialisation
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int p = 0; p < NUM_PATHS; p++) begin
				cable_hi_q[p] <= 8'h00;
				board_q[p] <= 4'h0;
			end
		end else if (id_wr_en) begin
			for (int p = 0; p < NUM_PATHS; p++) begin
				if (id_wr_path == PATH_W'(p)) begin
					cable_hi_q[p] <= id_cable_hi;
					board_q[p] <= id_board;
				end
			end
		end
	end

	// ==========================================================================
	// fifo control unit sequence
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= FCU_IDLE;
			hdr_idx_q <= 2'h0;
			fe_readout_clk_en <= 1'b0;
		end else begin
			case (state_q)
				FCU_IDLE: begin
					hdr_idx_q <= 2'h0;
					if (readout_start) state_q <= FCU_HEADER;
				end
				FCU_HEADER: begin
					hdr_idx_q <= hdr_idx_q + 2'h1;
					if (hdr_idx_q == HDR_LAST) begin
						state_q <= FCU_READ;
						fe_readout_clk_en <= 1'b1;
					end
				end
				FCU_READ: begin
					if (end_req) begin
						state_q <= FCU_DRAIN;
						fe_readout_clk_en <= 1'b0;
					end
				end
				FCU_DRAIN: begin
					if (&path_idle) state_q <= FCU_EOR;
				end
				FCU_EOR: begin
					if (&path_done) state_q <= FCU_IDLE;
				end
				default: begin
					state_q <= FCU_IDLE;
					fe_readout_clk_en <= 1'b0;
				end
			endcase
		end
	end

	// abort is sticky for the record; a new abort wins over the clear at start
	always_ff @(posedge clk or posedge reset) begin
		if (reset) abort_q <= 1'b0;
		else if (readout_abort && state_q == FCU_READ) abort_q <= 1'b1;
		else if (start_ok) abort_q <= 1'b0;
	end

	// header bytes first, then either link bytes or one test byte broadcast to all
	assign inj_bypass = (state_q == FCU_HEADER);
	assign inj_en = inj_bypass | (state_q == FCU_READ & test_mode & test_wr_en);
	assign link_wr_en = (state_q == FCU_READ) & ~test_mode;

	always_comb begin
		for (int p = 0; p < NUM_PATHS; p++) begin
			inj_data[p] = test_byte;
			if (inj_bypass) begin
				case (hdr_idx_q)
					2'h0: inj_data[p] = cable_hi_q[p];
					2'h1: inj_data[p] = {board_q[p], 4'(p)};
					2'h2: inj_data[p] = bunch_q;
					default: inj_data[p] = {6'h00, be_state_q};
				endcase
			end
		end
	end

	// ==========================================================================
	// per-link padding target: longest record on the link plus the minimum tail
	always_comb begin
		for (int l = 0; l < NUM_LINKS; l++) target_d[l] = '0;
		for (int p = 0; p < NUM_PATHS; p++) begin
			if (count_q[p] + EOR_MIN_FRAMES > target_d[link_of(p)]) begin
				target_d[link_of(p)] = count_q[p] + EOR_MIN_FRAMES;
			end
		end
	end

	// frozen when the tail starts so every path of a link pads to the same length
	always_ff @(posedge clk or posedge reset) begin
		if (reset) link_target_q <= '0;
		else if (state_q == FCU_DRAIN && (&path_idle)) link_target_q <= target_d;
	end

	// ==========================================================================
	// paths and output fifos
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PATHS; gp++) begin : g_path
			logic [7:0] out_mem [OUT_DEPTH];
			logic [OUT_AW:0] wr_q, rd_q;
			logic [1:0] eor_n_q;
			logic trunc_q, full, host_wr, wr_req;
			logic [7:0] wr_data, eor_code;

			dpf_path u_path (
				.clk(clk),
				.reset(reset),
				.link_byte(link_byte[gp]),
				.link_valid_toggle(link_byte_valid[gp]),
				.link_wr_en(link_wr_en),
				.inj_en(inj_en),
				.inj_bypass(inj_bypass),
				.inj_data(inj_data[gp]),
				.ped_wr_en(ped_wr_en && ped_wr_path == PATH_W'(gp)),
				.ped_wr_chan(ped_wr_chan),
				.ped_wr_value(ped_wr_value),
				.proc_valid(proc_valid[gp]),
				.proc_data(proc_data[gp]),
				.idle(path_idle[gp])
			);

			assign full = (wr_q[OUT_AW] != rd_q[OUT_AW]) && (wr_q[OUT_AW-1:0] == rd_q[OUT_AW-1:0]);
			assign empty[gp] = (wr_q == rd_q);
			assign path_done[gp] = count_q[gp] >= link_target_q[link_of(gp)];
			assign eor_wr[gp] = (state_q == FCU_EOR) & ~path_done[gp];
			assign host_wr = host_fifo_wr_en & (host_fifo_wr_path == PATH_W'(gp));
			assign wr_req = host_wr | eor_wr[gp] | proc_valid[gp];
			assign rd_word[gp] = out_mem[rd_q[OUT_AW-1:0]];

			// status frame reports abort over truncate over normal
			always_comb begin
				if (abort_q) eor_code = RECORD_END_ABORT;
				else if (trunc_q) eor_code = RECORD_END_TRUNCATE;
				else eor_code = RECORD_END_NORMAL;
			end

			// host pattern beats the tail, the tail beats the processed stream
			always_comb begin
				if (host_wr) wr_data = host_fifo_wr_data;
				else if (eor_wr[gp]) wr_data = (eor_n_q < EOR_STATUS_FRAMES) ? eor_code
					: RECORD_END_FILL;
				else wr_data = proc_data[gp];
			end

			always_ff @(posedge clk) begin
				if (wr_req && !full) out_mem[wr_q[OUT_AW-1:0]] <= wr_data;
			end

			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					wr_q <= '0;
					rd_q <= '0;
				end else begin
					if (wr_req && !full) wr_q <= wr_q + 1'b1;
					if (pop[gp]) rd_q <= rd_q + 1'b1;
				end
			end

			// record length counts attempts so a full fifo cannot stall the tail
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					count_q[gp] <= '0;
					eor_n_q <= 2'h0;
				end else if (start_ok) begin
					count_q[gp] <= '0;
					eor_n_q <= 2'h0;
				end else if (eor_wr[gp] || proc_valid[gp]) begin
					count_q[gp] <= count_q[gp] + 1'b1;
					if (eor_wr[gp] && eor_n_q < EOR_STATUS_FRAMES) eor_n_q <= eor_n_q + 2'h1;
				end
			end

			// a processed byte lost at a full fifo marks the record truncated; loss wins over the clear
			always_ff @(posedge clk or posedge reset) begin
				if (reset) trunc_q <= 1'b0;
				else if (proc_valid[gp] && full) trunc_q <= 1'b1;
				else if (start_ok) trunc_q <= 1'b0;
			end

			assign pop[gp] = drain[link_of(gp)] |
				(host_rd_ok & (host_fifo_rd_path == PATH_W'(gp)) & ~empty[gp]);
		end
	endgenerate

	// ==========================================================================
	// serial link controller
	always_comb begin
		grp_ready = '1;
		for (int p = 0; p < NUM_PATHS; p++) begin
			if (empty[p]) grp_ready[link_of(p)] = 1'b0;
		end
	end

	// disabled links hold everything in the fifos for the host
	assign drain = link_disable ? '0 : grp_ready;

	// each link word carries one byte from every path on that link, side by side
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			link_word <= '0;
			link_word_valid <= '0;
		end else begin
			link_word_valid <= drain;
			for (int p = 0; p < NUM_PATHS; p++) begin
				if (drain[link_of(p)]) link_word[link_of(p)][lane_of(p)*8 +: 8] <= rd_word[p];
			end
		end
	end

	// ==========================================================================
	// host readback, only while links are disabled so the two never race
	assign host_rd_ok = host_fifo_rd_en & link_disable;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			host_fifo_rd_data <= 8'h00;
			host_fifo_rd_valid <= 1'b0;
		end else begin
			host_fifo_rd_valid <= 1'b0;
			for (int p = 0; p < NUM_PATHS; p++) begin
				if (host_rd_ok && host_fifo_rd_path == PATH_W'(p) && !empty[p]) begin
					host_fifo_rd_data <= rd_word[p];
					host_fifo_rd_valid <= 1'b1;
				end
			end
		end
	end

	// status outputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			out_fifo_empty <= '1;
			record_busy <= 1'b0;
		end else begin
			out_fifo_empty <= empty;
			record_busy <= (state_q != FCU_IDLE);
		end
	end

endmodule // dpf_framer

`default_nettype wire

// ===== sim/dpf_cable_model.sv
// Purpose: cable-side model feeding bytes and a toggling valid to every readout path
// Assumes: one byte for each send pulse, the same byte on all ten cables
// Notes: each valid level stands four clocks or more, slow enough for the sync stage
`timescale 1ns/1ps
`default_nettype none

module dpf_cable_model
	import dpf_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic send,
	input wire logic [7:0] data,
	output logic [NUM_PATHS-1:0][7:0] link_byte,
	output logic [NUM_PATHS-1:0] link_byte_valid,
	output logic busy
);
	// ==========================================================================
	// byte launch
	logic [1:0] hold_q;

	// byte and toggle change together, zero skew as on the real cable
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			link_byte <= '0;
			link_byte_valid <= '0;
			hold_q <= 2'h0;
		end else if (send && hold_q == 2'h0) begin
			link_byte <= {NUM_PATHS{data}};
			link_byte_valid <= ~link_byte_valid;
			hold_q <= 2'h3;
		end else if (hold_q != 2'h0) begin
			hold_q <= hold_q - 2'h1;
		end
	end
	assign busy = (hold_q != 2'h0);
endmodule // dpf_cable_model
`default_nettype wire

// ===== sim/dpf_framer_asserts.sv
// Purpose: port-level checks of readout sequencing, draining and host reads
// Assumes: one clock domain, reset asynchronous and active high
// Notes: header lead allows one cycle of slack for the output register
`timescale 1ns/1ps
`default_nettype none

module dpf_framer_asserts
	import dpf_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic readout_start,
	input wire logic readout_done,
	input wire logic readout_abort,
	input wire logic link_disable,
	input wire logic host_fifo_rd_en,
	input wire logic fe_readout_clk_en,
	input wire logic host_fifo_rd_valid,
	input wire logic [NUM_LINKS-1:0] link_word_valid,
	input wire logic [NUM_PATHS-1:0] out_fifo_empty,
	input wire logic record_busy
);
	// ==========================================================================
	// properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_header_lead: assert property (readout_start && !record_busy && !fe_readout_clk_en
		|=> !fe_readout_clk_en[*4] ##[1:2] fe_readout_clk_en) else $error("enable before header");
	a_start_busy: assert property (readout_start && !record_busy && !fe_readout_clk_en
		|-> ##3 record_busy) else $error("record not busy after start");
	a_enable_holds: assert property (fe_readout_clk_en && !readout_done && !readout_abort
		|=> fe_readout_clk_en) else $error("readout enable dropped early");
	a_enable_drops: assert property (fe_readout_clk_en && (readout_done || readout_abort)
		|-> ##[1:2] !fe_readout_clk_en) else $error("readout enable stuck");
	a_enable_in_record: assert property (fe_readout_clk_en |-> record_busy)
		else $error("enable outside record");
	a_drain_held: assert property (|link_word_valid |-> !$past(link_disable))
		else $error("link sent while disabled");
	a_read_needs_disable: assert property (host_fifo_rd_en && !link_disable
		|=> !host_fifo_rd_valid) else $error("host read while links enabled");
	a_read_cause: assert property (host_fifo_rd_valid
		|-> $past(host_fifo_rd_en) && $past(link_disable)) else $error("read data without request");
	a_reset_state: assert property ($fell(reset) |-> (&out_fifo_empty) && !record_busy)
		else $error("fifos not empty after reset");
endmodule // dpf_framer_asserts

bind dpf_framer dpf_framer_asserts u_asserts (.clk, .reset, .readout_start, .readout_done,
	.readout_abort, .link_disable, .host_fifo_rd_en, .fe_readout_clk_en, .host_fifo_rd_valid,
	.link_word_valid, .out_fifo_empty, .record_busy);
`default_nettype wire

// ===== sim/detector_data_pipeline_framer_bench.sv
// Purpose: self-checking bench for the readout framer
// Assumes: inputs change 2 ns after the rising edge
// Notes: first record is held for host readback, second drains to the links
`timescale 1ns/1ps
`default_nettype none

module detector_data_pipeline_framer_bench;
	import dpf_pkg::*;
	logic clk, reset, send, cab_busy, digitize_cmd, readout_start, readout_done, readout_abort;
	logic test_mode, test_wr_en, id_wr_en, ped_wr_en, link_disable, host_fifo_wr_en;
	logic host_fifo_rd_en, fe_readout_clk_en, host_fifo_rd_valid, record_busy;
	logic [7:0] send_byte, cmd_bunch_crossing, test_byte, id_cable_hi, ped_wr_value;
	logic [7:0] host_fifo_wr_data, host_fifo_rd_data;
	logic [1:0] cmd_backend_state;
	logic [PATH_W-1:0] id_wr_path, ped_wr_path, host_fifo_wr_path, host_fifo_rd_path;
	logic [3:0] id_board;
	logic [6:0] ped_wr_chan;
	logic [NUM_PATHS-1:0][7:0] link_byte;
	logic [NUM_PATHS-1:0] link_byte_valid, out_fifo_empty;
	logic [NUM_LINKS-1:0][LANE_W-1:0] link_word;
	logic [NUM_LINKS-1:0] link_word_valid;
	int err_count, checked, p;
	logic [7:0] q3[$];
	logic [LANE_W-1:0] q0[$];
	// rows: cable byte in, processed byte out (pedestal 10 on channel 5)
	logic [15:0] rows[8] = '{16'hA3A3, 16'h1212, 16'h0505, 16'h3020, 16'h0505, 16'h0800,
		16'h8383, 16'h4444};
	logic [7:0] exp3[10] = '{8'h49, 8'h79, 8'h33, 8'h01, 8'hB1, 8'h00, 8'hC8, 8'hC8, 8'hC4, 8'hC4};

	dpf_framer DUT (.clk, .reset, .link_byte, .link_byte_valid, .digitize_cmd, .cmd_bunch_crossing,
		.cmd_backend_state, .readout_start, .readout_done, .readout_abort, .test_mode, .test_wr_en,
		.test_byte, .id_wr_en, .id_wr_path, .id_cable_hi, .id_board, .ped_wr_en, .ped_wr_path,
		.ped_wr_chan, .ped_wr_value, .link_disable, .host_fifo_wr_en, .host_fifo_wr_path,
		.host_fifo_wr_data, .host_fifo_rd_en, .host_fifo_rd_path, .fe_readout_clk_en,
		.host_fifo_rd_data, .host_fifo_rd_valid, .link_word, .link_word_valid, .out_fifo_empty,
		.record_busy);
	dpf_cable_model u_cable (.clk, .reset, .send, .data(send_byte), .link_byte, .link_byte_valid,
		.busy(cab_busy));

	// ==========================================================================
	// clock, link monitor, watchdog
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// link 3 carries path 9 alone, so its lane 0 is that path's record
	always @(posedge clk) begin
		if (link_word_valid[3] === 1'b1) q3.push_back(link_word[3][7:0]);
		if (link_word_valid[0] === 1'b1) q0.push_back(link_word[0]);
	end
	initial begin
		repeat (30000) @(posedge clk);
		err_count++;
		end_sim;
	end

	// ==========================================================================
	// tasks
	task automatic tick;
		@(posedge clk);
		#2;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic strobe(ref logic s);
		s = 1'b1;
		tick;
		s = 1'b0;
		tick;
	endtask
	// one host pop; an empty fifo must give no valid
	task automatic rd(input int path, input logic ev, input logic [7:0] exp);
		host_fifo_rd_path = PATH_W'(path);
		host_fifo_rd_en = 1'b1;
		tick;
		host_fifo_rd_en = 1'b0;
		chk({host_fifo_rd_valid, ev ? host_fifo_rd_data : 8'h00}, {ev, exp});
		tick;
	endtask
	// bunch crossing is changed after the command to prove it was latched
	task automatic open_record(input logic [1:0] st, input logic [7:0] bx);
		cmd_backend_state = st;
		cmd_bunch_crossing = bx;
		strobe(digitize_cmd);
		cmd_bunch_crossing = ~bx;
		strobe(readout_start);
		for (int n = 0; n < 20 && fe_readout_clk_en !== 1'b1; n++) tick;
		chk(fe_readout_clk_en, 1'b1);
	endtask
	task automatic close_record(ref logic s);
		strobe(s);
		for (int n = 0; n < 400 && record_busy !== 1'b0; n++) tick;
		chk(record_busy, 1'b0);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ==========================================================================
	// main sequence
	initial begin
		{digitize_cmd, readout_start, readout_done, readout_abort, test_mode, test_wr_en} = '0;
		{id_wr_en, ped_wr_en, link_disable, host_fifo_wr_en, host_fifo_rd_en, send} = '0;
		{cmd_bunch_crossing, test_byte, id_cable_hi, ped_wr_value, host_fifo_wr_data} = '0;
		{send_byte, cmd_backend_state, id_wr_path, ped_wr_path, id_board, ped_wr_chan} = '0;
		{host_fifo_wr_path, host_fifo_rd_path} = '0;
		err_count = 0;
		checked = 0;
		reset = 1'b1;
		repeat (10) @(posedge clk);
		#2 reset = 1'b0;
		chk({out_fifo_empty, fe_readout_clk_en, record_busy, link_word_valid}, 16'hFFC0);
		// cable ids and pedestals, one write pair per path
		for (p = 0; p < NUM_PATHS; p++) begin
			id_wr_path = PATH_W'(p);
			ped_wr_path = PATH_W'(p);
			id_cable_hi = 8'h40 + 8'(p);
			id_board = 4'h7;
			ped_wr_chan = 7'h05;
			ped_wr_value = 8'h10;
			id_wr_en = 1'b1;
			ped_wr_en = 1'b1;
			tick;
			id_wr_en = 1'b0;
			ped_wr_en = 1'b0;
			tick;
		end
		// record from the cables, held back for host readback
		link_disable = 1'b1;
		open_record(BE_READ, 8'h5A);
		foreach (rows[i]) begin
			while (cab_busy === 1'b1) tick;
			send_byte = rows[i][15:8];
			send = 1'b1;
			tick;
			send = 1'b0;
			repeat (4) tick;
		end
		close_record(readout_done);
		for (p = 0; p < NUM_PATHS; p++) begin
			rd(p, 1'b1, 8'h40 + 8'(p));
			rd(p, 1'b1, {4'h7, 4'(p)});
			rd(p, 1'b1, 8'h5A);
			rd(p, 1'b1, 8'h02);
			foreach (rows[i]) rd(p, 1'b1, rows[i][7:0]);
			rd(p, 1'b1, 8'hC1);
			rd(p, 1'b1, 8'hC1);
			rd(p, 1'b1, 8'hC4);
			rd(p, 1'b1, 8'hC4);
			rd(p, 1'b0, 8'h00);
		end
		// test-mode record, aborted, drained straight to the links
		link_disable = 1'b0;
		test_mode = 1'b1;
		open_record(BE_DIGITIZE, 8'h33);
		test_byte = 8'hB1;
		strobe(test_wr_en);
		test_byte = 8'h00;
		strobe(test_wr_en);
		close_record(readout_abort);
		repeat (20) tick;
		chk(q0[0], 24'h424140);
		foreach (exp3[i]) chk(q3[i], exp3[i]);
		// host pattern goes out like normal data
		test_mode = 1'b0;
		host_fifo_wr_path = 4'h9;
		host_fifo_wr_data = 8'h77;
		strobe(host_fifo_wr_en);
		repeat (6) tick;
		chk(q3[10], 8'h77);
		chk(24'(q3.size()), 24'h00000B);
		// a lone byte on a shared link must wait, and the host may not pop it while enabled
		host_fifo_wr_path = 4'h0;
		strobe(host_fifo_wr_en);
		rd(0, 1'b0, 8'h00);
		chk(24'(q0.size()), 24'h00000A);
		chk(24'(out_fifo_empty), 24'h0003FE);
		end_sim;
	end
endmodule // detector_data_pipeline_framer_bench
`default_nettype wire
